// ---- trb_timer.sv ----
/*
 * 8-bit up-counting timer and event counter with double-buffered reload,
 * buzzer toggle output and PWM output, behind an AXI4-Lite slave.
 * Assumes a 20 MHz clk, synchronous active-high srst, and an external
 * event pin asynchronous to clk.
 */
`timescale 1ns/10ps
module trb_timer #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // AXI4-Lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // External event pin
   input wire logic externalEventInput,
   // Shared output pin and interrupt request
   output trb_pkg::trb_pin_t sharedOutputPin,
   output logic timerIrqRequest
);
   trb_pkg::trb_state_t s;
   trb_pkg::trb_state_t next_s;

   logic extLevel;
   logic timerEnableBit;
   logic pwmOutputEnable;
   logic toggleOutputEnable;
   logic autoReloadEnable;
   logic clockSourceSelect;
   logic [2:0] rateSelect;
   logic [7:0] modMask;
   logic [7:0] preMask;
   logic intTick;
   logic extFall;
   logic countTick;
   logic overflow;
   logic awFire;
   logic wFire;
   logic arFire;
   logic wrDo;
   logic [7:0] wrIdx;
   logic [7:0] wrData;
   logic wrLane0;
   logic [7:0] arIdx;
   logic countWrite;

   // External event pin through the filter
   trb_pin_sync u_ext_sync (
      .clk(clk),
      .srst(srst),
      .pinIn(externalEventInput),
      .level(extLevel)
   );

   // Mode fields
   assign timerEnableBit = s.mode[trb_pkg::MODE_EN_BIT];
   assign pwmOutputEnable = s.mode[trb_pkg::MODE_PWM_BIT];
   assign toggleOutputEnable = s.mode[trb_pkg::MODE_TOGGLE_BIT];
   assign autoReloadEnable = s.mode[trb_pkg::MODE_ALOAD_BIT];
   assign clockSourceSelect = s.mode[trb_pkg::MODE_CKS_BIT];
   assign rateSelect = s.mode[trb_pkg::MODE_RATE_LSB +: 3];

   // Overflow boundary select
   always_comb begin
      modMask = trb_pkg::MASK_256;
      if (pwmOutputEnable && !clockSourceSelect) begin
         case ({autoReloadEnable, toggleOutputEnable})
            2'b00: modMask = trb_pkg::MASK_256;
            2'b01: modMask = trb_pkg::MASK_64;
            2'b10: modMask = trb_pkg::MASK_32;
            2'b11: modMask = trb_pkg::MASK_16;
            default: modMask = trb_pkg::MASK_256;
         endcase
      end
   end

   // Count clock: prescaler tap or filtered falling edge
   assign preMask = trb_pkg::MASK_256 >> rateSelect;
   assign intTick = ((s.pre & preMask) == preMask);
   assign extFall = s.extLast && !extLevel;
   assign countTick = timerEnableBit && (clockSourceSelect ? extFall : intTick);
   assign overflow = countTick && ((s.count & modMask) == modMask);

   // Bus handshakes and the write that completes once both halves are in
   assign s_axi_awready = !s.awHeld && !s.bValid;
   assign s_axi_wready = !s.wHeld && !s.bValid;
   assign s_axi_arready = !s.rValid;
   assign awFire = s_axi_awvalid && s_axi_awready;
   assign wFire = s_axi_wvalid && s_axi_wready;
   assign arFire = s_axi_arvalid && s_axi_arready;
   assign wrDo = (s.awHeld || awFire) && (s.wHeld || wFire);
   assign wrIdx = s.awHeld ? s.awIdx : s_axi_awaddr[9:2];
   assign wrData = s.wHeld ? s.wData : s_axi_wdata[7:0];
   assign wrLane0 = s.wHeld ? s.wLane0 : s_axi_wstrb[0];
   assign arIdx = s_axi_araddr[9:2];
   assign countWrite = wrDo && wrLane0 && (wrIdx == trb_pkg::IDX_COUNT);

   // Next state
   always_comb begin
      next_s = s;
      next_s.pre = s.pre + 8'h01;
      next_s.extLast = extLevel;
      // Counting and overflow handling
      if (countTick) begin
         next_s.count = (s.count + 8'h01) & modMask;
      end
      if (overflow) begin
         next_s.reloadAct = s.reloadBuf;
         next_s.irqFlag = 1'b1;
         if (pwmOutputEnable) begin
            next_s.count = 8'h00;
         end else if (autoReloadEnable) begin
            next_s.count = s.reloadAct;
         end
         if (toggleOutputEnable && !pwmOutputEnable) begin
            next_s.buzz = !s.buzz;
         end
      end
      // Write channel capture
      if (awFire && !wrDo) begin
         next_s.awHeld = 1'b1;
         next_s.awIdx = s_axi_awaddr[9:2];
      end
      if (wFire && !wrDo) begin
         next_s.wHeld = 1'b1;
         next_s.wData = s_axi_wdata[7:0];
         next_s.wLane0 = s_axi_wstrb[0];
      end
      if (s.bValid && s_axi_bready) begin
         next_s.bValid = 1'b0;
      end
      // Register write
      if (wrDo) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld = 1'b0;
         next_s.bValid = 1'b1;
         next_s.bResp = trb_pkg::RESP_OKAY;
         case (wrIdx)
            trb_pkg::IDX_MODE: begin
               if (wrLane0) begin
                  next_s.mode = wrData;
               end
            end
            trb_pkg::IDX_COUNT: begin
               if (wrLane0) begin
                  next_s.count = wrData;
               end
            end
            trb_pkg::IDX_RELOAD: begin
               if (wrLane0) begin
                  next_s.reloadBuf = wrData;
               end
            end
            trb_pkg::IDX_IRQ: begin
               if (wrLane0) begin
                  next_s.irqEn = wrData[trb_pkg::IRQ_EN_BIT];
                  // Write one clears; a same-cycle overflow wins
                  if (wrData[trb_pkg::IRQ_FLAG_BIT] && !overflow) begin
                     next_s.irqFlag = 1'b0;
                  end
               end
            end
            default: begin
               next_s.bResp = trb_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Register read
      if (s.rValid && s_axi_rready) begin
         next_s.rValid = 1'b0;
      end
      if (arFire) begin
         next_s.rValid = 1'b1;
         next_s.rResp = trb_pkg::RESP_OKAY;
         next_s.rData = 32'h0000_0000;
         case (arIdx)
            trb_pkg::IDX_MODE: next_s.rData[7:0] = s.mode;
            trb_pkg::IDX_COUNT: next_s.rData[7:0] = s.count;
            trb_pkg::IDX_RELOAD: next_s.rData[7:0] = 8'h00;
            trb_pkg::IDX_IRQ: begin
               next_s.rData[trb_pkg::IRQ_EN_BIT] = s.irqEn;
               next_s.rData[trb_pkg::IRQ_FLAG_BIT] = s.irqFlag;
            end
            default: next_s.rResp = trb_pkg::RESP_SLVERR;
         endcase
      end
      // PWM compare against the active reload, frozen while disabled
      if (timerEnableBit && pwmOutputEnable) begin
         next_s.pwmOut = ((next_s.count & modMask) < (next_s.reloadAct & modMask));
      end
      // Shared pin: PWM first, buzzer only with PWM off
      next_s.pin.owned = next_s.mode[trb_pkg::MODE_PWM_BIT] ||
         next_s.mode[trb_pkg::MODE_TOGGLE_BIT];
      next_s.pin.level = next_s.mode[trb_pkg::MODE_PWM_BIT] ? next_s.pwmOut : next_s.buzz;
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         s <= '0;
         s.mode <= trb_pkg::RST_MODE;
         s.count <= trb_pkg::RST_COUNT;
         s.reloadBuf <= trb_pkg::RST_RELOAD;
         s.reloadAct <= trb_pkg::RST_RELOAD;
         s.extLast <= trb_pkg::RST_EXT_LEVEL;
      end else begin
         s <= next_s;
      end
   end

   // Outputs
   assign s_axi_bvalid = s.bValid;
   assign s_axi_bresp = s.bResp;
   assign s_axi_rvalid = s.rValid;
   assign s_axi_rdata = s.rData;
   assign s_axi_rresp = s.rResp;
   assign sharedOutputPin = s.pin;
   assign timerIrqRequest = s.irqFlag && s.irqEn;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_RELOAD_COPY: assert property (
      overflow && autoReloadEnable && !pwmOutputEnable && !countWrite
      |=> s.count == $past(s.reloadAct))
      else $error("counter not reloaded at overflow");
   AST_BUFFER_HOLD: assert property (
      !overflow |=> s.reloadAct == $past(s.reloadAct))
      else $error("active reload changed without overflow");
   AST_BUFFER_MOVE: assert property (
      overflow |=> s.reloadAct == $past(s.reloadBuf))
      else $error("reload buffer not moved at overflow");
   AST_PWM_WRAP: assert property (
      overflow && pwmOutputEnable && !countWrite |=> s.count == 8'h00)
      else $error("PWM period did not restart at zero");
   AST_RELOAD_READ_ZERO: assert property (
      arFire && arIdx == trb_pkg::IDX_RELOAD |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
      else $error("reload register read not zero");
   AST_MOD16: assert property (
      countTick && pwmOutputEnable && !clockSourceSelect && autoReloadEnable &&
      toggleOutputEnable && s.count[3:0] == 4'hF |-> overflow)
      else $error("modulus 16 boundary missed");
   AST_BUZZ_TOGGLE: assert property (
      overflow && toggleOutputEnable && !pwmOutputEnable |=> s.buzz != $past(s.buzz))
      else $error("buzzer did not toggle");
   AST_HALT: assert property (
      !timerEnableBit && !countWrite && !wrDo |=> $stable(s.count) && $stable(s.pin))
      else $error("disabled timer moved");
   AST_PWM_COMPARE: assert property (
      $past(timerEnableBit && pwmOutputEnable) && $stable(s.mode)
      |-> s.pwmOut == ((s.count & modMask) < (s.reloadAct & modMask)))
      else $error("PWM level disagrees with compare");
   AST_PWM_ZERO_LOW: assert property (
      $past(timerEnableBit && pwmOutputEnable) && s.reloadAct == 8'h00 |-> !s.pwmOut)
      else $error("PWM high with zero reload");
   AST_IRQ_SET: assert property (
      overflow |=> s.irqFlag [*2] or (s.irqFlag ##1 1'b1))
      else $error("overflow did not set request flag");
   AST_COUNT_INC: assert property (
      countTick && !overflow && !countWrite |=> s.count == $past(s.count) + 8'h01)
      else $error("counter did not increment");
   AST_EXT_ONLY: assert property (
      clockSourceSelect && !extFall && !countWrite |=> $stable(s.count))
      else $error("event counter moved without falling edge");
   AST_PWM_HIGH_AT_WRAP: assert property (
      overflow && pwmOutputEnable && !countWrite && (s.reloadBuf & modMask) != 8'h00
      |=> s.pwmOut)
      else $error("PWM not high at period start");
   AST_PLAIN_WRAP: assert property (
      overflow && !autoReloadEnable && !pwmOutputEnable && !countWrite |=> s.count == 8'h00)
      else $error("counter did not wrap to zero");
   AST_EVENT_MOD: assert property (
      clockSourceSelect && countTick |-> overflow == (s.count == 8'hFF))
      else $error("event counter boundary not 256");
   AST_RELOAD_WRITE: assert property (
      wrDo && wrLane0 && wrIdx == trb_pkg::IDX_RELOAD |=> s.reloadBuf == $past(wrData))
      else $error("reload write missed holding buffer");
   AST_PIN_OWNED: assert property (
      sharedOutputPin.owned == (pwmOutputEnable || toggleOutputEnable))
      else $error("pin ownership wrong");
   AST_PIN_LEVEL: assert property (
      sharedOutputPin.level == (pwmOutputEnable ? s.pwmOut : s.buzz))
      else $error("pin level not from selected function");
   AST_NO_BUZZ_IN_PWM: assert property (
      pwmOutputEnable |=> s.buzz == $past(s.buzz))
      else $error("buzzer toggled in PWM mode");
   AST_OUT_FREEZE: assert property (
      !timerEnableBit |=> s.pwmOut == $past(s.pwmOut) && s.buzz == $past(s.buzz))
      else $error("outputs moved while disabled");
   AST_IRQ_HOLD: assert property (
      !overflow && !wrDo |=> s.irqFlag == $past(s.irqFlag))
      else $error("request flag changed without cause");
   // Prescaler taps at the fastest and slowest rates
   AST_RATE_FAST: assert property (
      intTick && rateSelect == 3'h7 |=> !intTick ##1 (intTick || rateSelect != 3'h7))
      else $error("fastest rate not every second cycle");
   AST_RATE_SLOW: assert property (
      intTick && rateSelect == 3'h0 |-> ##256 (intTick || rateSelect != 3'h0))
      else $error("slowest rate not every 256 cycles");
endmodule

// ---- trb_pkg.sv ----
/*
 * Shared constants and types for the reload timer with buzzer and PWM output.
 * Assumes one 20 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package trb_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RELOAD = 8'hCD;
   localparam logic [7:0] IDX_MODE = 8'hDA;
   localparam logic [7:0] IDX_COUNT = 8'hDB;
   localparam logic [7:0] IDX_IRQ = 8'hC0;
   // Mode register fields
   localparam int MODE_PWM_BIT = 0;
   localparam int MODE_TOGGLE_BIT = 1;
   localparam int MODE_ALOAD_BIT = 2;
   localparam int MODE_CKS_BIT = 3;
   localparam int MODE_RATE_LSB = 4;
   localparam int MODE_EN_BIT = 7;
   // Interrupt register fields
   localparam int IRQ_EN_BIT = 0;
   localparam int IRQ_FLAG_BIT = 1;
   // Reset values
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_RELOAD = 8'h00;
   localparam logic RST_EXT_LEVEL = 1'b1;
   // Modulus masks for the PWM boundary select
   localparam logic [7:0] MASK_256 = 8'hFF;
   localparam logic [7:0] MASK_64 = 8'h3F;
   localparam logic [7:0] MASK_32 = 8'h1F;
   localparam logic [7:0] MASK_16 = 8'h0F;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Pin synchroniser state
   typedef struct packed {
      logic [2:0] stage;
      logic level;
   } trb_sync_t;

   // Pin facing outputs
   typedef struct packed {
      logic level;
      logic owned;
   } trb_pin_t;

   // Whole timer state
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] count;
      logic [7:0] reloadBuf;
      logic [7:0] reloadAct;
      logic [7:0] pre;
      logic irqEn;
      logic irqFlag;
      logic buzz;
      logic pwmOut;
      logic extLast;
      trb_pin_t pin;
      logic awHeld;
      logic wHeld;
      logic [7:0] awIdx;
      logic [7:0] wData;
      logic wLane0;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } trb_state_t;
endpackage

// ---- trb_pin_sync.sv ----
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the pin is asynchronous to clk; output level is idle high.
 */
`timescale 1ns/10ps
module trb_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Pin and filtered level
   input wire logic pinIn,
   output logic level
);
   trb_pkg::trb_sync_t s;
   trb_pkg::trb_sync_t next_s;

   // Shift the pin in; accept a level once stages two and three agree
   always_comb begin
      next_s = s;
      next_s.stage = {s.stage[1:0], pinIn};
      if (s.stage[1] == s.stage[2]) begin
         next_s.level = s.stage[2];
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         s <= {{3{trb_pkg::RST_EXT_LEVEL}}, trb_pkg::RST_EXT_LEVEL};
      end else begin
         s <= next_s;
      end
   end

   assign level = s.level;
endmodule

// ---- trb_load_model.sv ----
/* Load on the shared output pin and source of external events.
   Assumes the pin struct of trb_pkg; the event line idles high. */
`timescale 1ns/10ps
module trb_load_model (
   // Clock
   input wire logic clk,
   // Pin under observation
   input wire trb_pkg::trb_pin_t pin,
   // Event line and tallies
   output logic evLine,
   output int highCnt,
   output int toggleCnt
);
   logic lastLvl;
   // Idle levels at time zero
   initial begin
      evLine = 1'b1;
      highCnt = 0;
      toggleCnt = 0;
      lastLvl = 1'b0;
   end
   // Tally high cycles and level changes while the pin is taken
   always @(posedge clk) begin
      if (pin.owned === 1'b1) begin
         highCnt <= highCnt + int'(pin.level === 1'b1);
         toggleCnt <= toggleCnt + int'(pin.level !== lastLvl);
      end
      lastLvl <= pin.level;
   end
   // Falling edges, four cycles low and four high each
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         evLine <= 1'b0;
         repeat (4) @(posedge clk);
         evLine <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule

// ---- tb_trb_timer.sv ----
/* Self-checking bench for the reload timer with buzzer and PWM.
   Assumes trb_pkg, trb_timer and trb_load_model; 20 MHz clock. */
`timescale 1ns/10ps
module tb_trb_timer;
   logic clk, srst, awvalid, wvalid, bready, arvalid, rready, evLine;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   trb_pkg::trb_pin_t pin;
   int highCnt, toggleCnt, errCount, nCompared, cycles, t;

   trb_timer u_dut (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .externalEventInput(evLine),
      .sharedOutputPin(pin), .timerIrqRequest(irq));
   trb_load_model u_load (.clk(clk), .pin(pin), .evLine(evLine),
      .highCnt(highCnt), .toggleCnt(toggleCnt));

   // Clock source
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         errCount = errCount + 1;
         endSim();
      end
   end

   task automatic endSim;
      if (errCount == 0 && nCompared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nCompared = nCompared + 1;
      if (g !== e) begin
         errCount = errCount + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Mode byte from enable, rate and low nibble {source, reload, toggle, pwm}
   function automatic logic [7:0] md(input logic en, input logic [2:0] r, input logic [3:0] l);
      return {en, r, l};
   endfunction
   // Bus write; response code left in resp
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a, w, b;
      @(posedge clk);
      awaddr <= 12'({idx, 2'h0});
      wdata <= 32'(d);
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clk);
         a = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         resp = bresp;
         @(posedge clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
   endtask
   // Bus read; data in rd, response code in resp
   task automatic rdr(input logic [7:0] idx);
      logic a, b;
      @(posedge clk);
      araddr <= 12'({idx, 2'h0});
      arvalid <= 1'b1;
      rready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clk);
         a = arvalid & arready;
         b = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge clk);
         if (a) arvalid <= 1'b0;
         if (b) rready <= 1'b0;
      end
   endtask

   // Reset values, write-only reload, unmapped place
   task automatic tRegs;
      rdr(trb_pkg::IDX_MODE);
      chk("mode", 32'(trb_pkg::RST_MODE), rd);
      rdr(trb_pkg::IDX_COUNT);
      chk("count", 32'(trb_pkg::RST_COUNT), rd);
      rdr(trb_pkg::IDX_RELOAD);
      chk("reload", 32'h0000_0000, rd);
      rdr(trb_pkg::IDX_IRQ);
      chk("irq", 32'h0000_0000, rd);
      rdr(8'h10);
      chk("rd resp", 32'(trb_pkg::RESP_SLVERR), 32'(resp));
      wr(8'h10, 8'hFF);
      chk("wr resp", 32'(trb_pkg::RESP_SLVERR), 32'(resp));
   endtask
   // Double-buffered auto-reload, flag, hold when stopped
   task automatic tReload;
      wr(trb_pkg::IDX_MODE, 8'h00);
      wr(trb_pkg::IDX_IRQ, 8'h03);
      wr(trb_pkg::IDX_COUNT, 8'hFF);
      wr(trb_pkg::IDX_RELOAD, 8'h80);
      wr(trb_pkg::IDX_MODE, md(1'b1, 3'h7, 4'h4));
      repeat (20) @(posedge clk);
      rdr(trb_pkg::IDX_COUNT);
      chk("old active", 32'h1, 32'(rd < 32));
      repeat (520) @(posedge clk);
      wr(trb_pkg::IDX_MODE, md(1'b0, 3'h7, 4'h4));
      rdr(trb_pkg::IDX_COUNT);
      chk("reloaded", 32'h1, 32'(rd >= 128 && rd < 160));
      t = int'(rd);
      chk("request", 32'h1, 32'(irq));
      repeat (40) @(posedge clk);
      rdr(trb_pkg::IDX_COUNT);
      chk("held", 32'(t), rd);
      wr(trb_pkg::IDX_IRQ, 8'h03);
      rdr(trb_pkg::IDX_IRQ);
      chk("cleared", 32'h0000_0001, rd);
      chk("request off", 32'h0, 32'(irq));
   endtask
   // External falling edges, rate field ignored
   task automatic tEvents;
      wr(trb_pkg::IDX_MODE, 8'h00);
      wr(trb_pkg::IDX_COUNT, 8'h00);
      wr(trb_pkg::IDX_MODE, md(1'b1, 3'h7, 4'h8));
      u_load.pulses(5);
      repeat (8) @(posedge clk);
      rdr(trb_pkg::IDX_COUNT);
      chk("events", 32'h5, rd);
      chk("free pin", 32'h0, 32'(pin.owned));
   endtask
   // Slowest internal rate ticks once per 256 cycles
   task automatic tRate;
      wr(trb_pkg::IDX_MODE, 8'h00);
      wr(trb_pkg::IDX_COUNT, 8'h00);
      wr(trb_pkg::IDX_MODE, md(1'b1, 3'h0, 4'h0));
      repeat (1024) @(posedge clk);
      wr(trb_pkg::IDX_MODE, md(1'b0, 3'h0, 4'h0));
      rdr(trb_pkg::IDX_COUNT);
      chk("slow rate", 32'h1, 32'(rd >= 4 && rd <= 5));
   endtask
   // Buzzer toggles once per 512-cycle overflow, stops when disabled
   task automatic tBuzz;
      wr(trb_pkg::IDX_MODE, 8'h00);
      wr(trb_pkg::IDX_COUNT, 8'h00);
      wr(trb_pkg::IDX_MODE, md(1'b1, 3'h7, 4'h2));
      repeat (20) @(posedge clk);
      t = toggleCnt;
      repeat (2048) @(posedge clk);
      chk("toggles", 32'h4, 32'(toggleCnt - t));
      chk("owned", 32'h1, 32'(pin.owned));
      wr(trb_pkg::IDX_MODE, md(1'b0, 3'h7, 4'h2));
      t = toggleCnt;
      repeat (1100) @(posedge clk);
      chk("frozen", 32'h0, 32'(toggleCnt - t));
   endtask
   // PWM duty over a 512-cycle window for one modulus select
   task automatic tPwm(input logic [1:0] s, input logic [7:0] r, input int e);
      wr(trb_pkg::IDX_MODE, 8'h00);
      wr(trb_pkg::IDX_IRQ, 8'h02);
      wr(trb_pkg::IDX_COUNT, 8'h00);
      wr(trb_pkg::IDX_RELOAD, r);
      wr(trb_pkg::IDX_MODE, md(1'b1, 3'h7, {1'b0, s, 1'b1}));
      repeat (600) @(posedge clk);
      t = highCnt;
      repeat (512) @(posedge clk);
      chk("high time", 32'(e), 32'(highCnt - t));
      chk("owned", 32'h1, 32'(pin.owned));
      rdr(trb_pkg::IDX_IRQ);
      chk("period flag", 32'h2, rd & 32'h0000_0002);
   endtask

   // Main sequence
   initial begin
      srst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      errCount = 0;
      nCompared = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      tRegs();
      tReload();
      tEvents();
      tRate();
      tBuzz();
      tPwm(2'h0, 8'h03, 6);
      tPwm(2'h1, 8'h03, 24);
      tPwm(2'h2, 8'h03, 48);
      tPwm(2'h3, 8'h03, 96);
      tPwm(2'h0, 8'h00, 0);
      endSim();
   end
endmodule
